// *** src/qdr_params.svh ***
// offsets, field positions and reset values of the queued read status block
`ifndef QDR_PARAMS_SVH
`define QDR_PARAMS_SVH
// register byte offsets
`define QDR_OFS_FAILURE_CAUSE   12'h000
`define QDR_OFS_TAG_AND_REASON  12'h004
`define QDR_OFS_ADDRESS_LOW     12'h008
`define QDR_OFS_ADDRESS_MID     12'h00C
`define QDR_OFS_ADDRESS_HIGH    12'h010
`define QDR_OFS_DRIVE_SELECT    12'h014
`define QDR_OFS_CONDITION_FLAGS 12'h018
`define QDR_OFS_CONTROL         12'h01C
`define QDR_OFS_EVENT           12'h020
`define QDR_OFS_CONFIG          12'h024
// condition_flags bits
`define QDR_ST_BUSY      7
`define QDR_ST_READY     6
`define QDR_ST_FAULT     5
`define QDR_ST_SERVICE   4
`define QDR_ST_XFER      3
`define QDR_ST_FAIL      0
// failure_cause bits
`define QDR_ER_CRC       7
`define QDR_ER_UNFIX     6
`define QDR_ER_SWAP      5
`define QDR_ER_NOADDR    4
`define QDR_ER_EJECT     3
`define QDR_ER_ABORT     2
`define QDR_ER_NOMEDIUM  1
// tag_and_reason bits
`define QDR_SC_TAG_HI    7
`define QDR_SC_TAG_LO    3
`define QDR_SC_LETGO     2
`define QDR_SC_TOHOST    1
`define QDR_SC_CTRL      0
// control register bits (write one to act)
`define QDR_CT_ISSUE     0
`define QDR_CT_RESUME    1
`define QDR_CT_QUERY     2
// config register bits
`define QDR_CF_QUEUING   0
`define QDR_CF_OVL_EN    1
`define QDR_CF_REMOVABLE 2
`define QDR_CF_SUPPORTED 3
// reset values
`define QDR_RST_STATUS   8'h40
`define QDR_RST_CONFIG   8'h0F
`endif

// *** src/qdr_pkg.sv ***
// types shared by the queued read status block
package qdr_pkg;
    typedef enum logic [1:0] {
        QDR_IMG_DATA,
        QDR_IMG_DONE,
        QDR_IMG_ERROR
    } qdr_image_t;

    typedef struct packed {
        logic crc;
        logic unfix;
        logic swap;
        logic noaddr;
        logic eject;
        logic abort;
        logic nomedium;
        logic fault;
    } qdr_fail_t;

    typedef struct packed {
        logic [7:0] cause;
        logic [7:0] count;
        logic [7:0] low;
        logic [7:0] mid;
        logic [7:0] high;
        logic [7:0] drive;
        logic [7:0] status;
    } qdr_image_regs_t;
endpackage

// *** src/qdr_image.sv ***
// builds register images for data, completion and error answers
`timescale 1ns/1ps
`include "qdr_params.svh"
module qdr_image (
    input  wire qdr_pkg::qdr_image_t      kind,
    input  wire logic [4:0]               tag,
    input  wire logic                     queuing,
    input  wire logic                     more_queued,
    input  wire logic                     dev_num,
    input  wire logic [27:0]              fail_addr,
    input  wire qdr_pkg::qdr_fail_t       fail,
    output qdr_pkg::qdr_image_regs_t      img
);
    logic [7:0] cause;
    always_comb
    begin
        cause = 8'h00;
        cause[`QDR_ER_CRC]      = fail.crc;
        cause[`QDR_ER_UNFIX]    = fail.unfix;
        cause[`QDR_ER_SWAP]     = fail.swap;
        cause[`QDR_ER_NOADDR]   = fail.noaddr;
        cause[`QDR_ER_EJECT]    = fail.eject;
        cause[`QDR_ER_ABORT]    = fail.abort;
        cause[`QDR_ER_NOMEDIUM] = fail.nomedium;
        img = '0;
        img.count[`QDR_SC_TAG_HI:`QDR_SC_TAG_LO] = queuing ? tag : 5'h00;
        img.drive[4] = dev_num;
        img.status[`QDR_ST_READY] = 1'b1;
        case (kind)
            qdr_pkg::QDR_IMG_DATA:
            begin
                img.count[`QDR_SC_TOHOST] = 1'b1;
                img.status[`QDR_ST_XFER]  = 1'b1;
                img.status[`QDR_ST_SERVICE] = more_queued;
            end
            qdr_pkg::QDR_IMG_DONE:
            begin
                img.cause = 8'h00;
                img.count[`QDR_SC_TOHOST] = 1'b1;
                img.count[`QDR_SC_CTRL]   = 1'b1;
                img.status[`QDR_ST_BUSY] = 1'b0;
                img.status[`QDR_ST_SERVICE] = more_queued;
            end
            qdr_pkg::QDR_IMG_ERROR:
            begin
                img.cause = cause;
                img.count[`QDR_SC_TOHOST] = 1'b1;
                img.count[`QDR_SC_CTRL]   = 1'b1;
                img.low  = fail_addr[7:0];
                img.mid  = fail_addr[15:8];
                img.high = fail_addr[23:16];
                img.drive[3:0] = fail_addr[27:24];
                img.status[`QDR_ST_FAULT] = fail.fault;
                img.status[`QDR_ST_FAIL]  = |cause;
                img.status[`QDR_ST_SERVICE] = more_queued;
            end
            default:
            begin
                img.cause = 8'h00;
            end
        endcase
    end
endmodule

// *** src/qdr_status.sv ***
// task-file status engine for a queued dma read, apb slave
`timescale 1ns/1ps
`include "qdr_params.svh"
module qdr_status (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // media engine events (one-cycle pulses), then level inputs
    input  wire logic        data_ready,
    input  wire logic        xfer_done,
    input  wire logic        err_unrecov,
    input  wire logic        err_crc,
    input  wire logic        err_range,
    input  wire logic        err_notfound,
    input  wire logic        err_fault,
    input  wire logic        ultra_mode,
    input  wire logic        medium_changed,
    input  wire logic        eject_request,
    input  wire logic        medium_present,
    input  wire logic        more_queued,
    input  wire logic [27:0] fail_addr,
    input  wire logic        tag_valid_limit_en,
    input  wire logic [4:0]  tag_limit,
    output logic             queue_flush,
    output logic             cmd_active
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        QDR_IDLE,
        QDR_XFER,
        QDR_RELEASED,
        QDR_WAIT_RESUME,
        QDR_END
    } qdr_state_t;

    qdr_state_t              state;
    qdr_state_t              next_state;
    qdr_pkg::qdr_image_regs_t regs;
    qdr_pkg::qdr_image_regs_t next_regs;
    qdr_pkg::qdr_fail_t      fail;
    qdr_pkg::qdr_fail_t      next_fail;
    qdr_pkg::qdr_image_t     pend;
    qdr_pkg::qdr_image_t     next_pend;
    logic [7:0]              cfg;
    logic [7:0]              next_cfg;
    logic                    swap_seen;
    logic                    next_swap_seen;
    logic                    eject_seen;
    logic                    next_eject_seen;
    logic                    flush;
    logic                    next_flush;
    logic [7:0]              event_bits;
    logic [7:0]              next_event_bits;
    qdr_pkg::qdr_image_regs_t img;
    qdr_pkg::qdr_image_t     img_kind;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    logic wr_en;
    logic rd_en;
    logic known;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    // zero wait states; unmapped offsets answer with an error
    assign pready  = 1'b1;
    assign known   = (paddr <= `QDR_OFS_CONFIG) && (paddr[1:0] == 2'b00);
    assign pslverr = psel & penable & ~known;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    logic issue_req;
    logic resume_req;
    logic query_req;
    assign issue_req  = wr_en & pstrb[0] & hit(paddr, `QDR_OFS_CONTROL) & pwdata[`QDR_CT_ISSUE];
    assign resume_req = wr_en & pstrb[0] & hit(paddr, `QDR_OFS_CONTROL) & pwdata[`QDR_CT_RESUME];
    assign query_req  = wr_en & pstrb[0] & hit(paddr, `QDR_OFS_CONTROL) & pwdata[`QDR_CT_QUERY];

    logic [4:0] cur_tag;
    assign cur_tag = regs.count[`QDR_SC_TAG_HI:`QDR_SC_TAG_LO];

    qdr_image u_image (
        .kind        (img_kind),
        .tag         (cur_tag),
        .queuing     (cfg[`QDR_CF_QUEUING]),
        .more_queued (more_queued),
        .dev_num     (regs.drive[4]),
        .fail_addr   (fail_addr),
        .fail        (next_fail),
        .img         (img)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_state      = state;
        next_regs       = regs;
        next_fail       = fail;
        next_pend       = pend;
        next_cfg        = cfg;
        next_flush      = 1'b0;
        next_event_bits = event_bits;
        img_kind        = pend;
        next_swap_seen  = swap_seen | medium_changed;
        next_eject_seen = eject_seen | eject_request;
        if (query_req)
        begin
            next_eject_seen = eject_request;
        end
        // host task-file writes while idle
        if (wr_en && state == QDR_IDLE)
        begin
            if (hit(paddr, `QDR_OFS_TAG_AND_REASON) && pstrb[0])
                next_regs.count = pwdata[7:0];
            if (hit(paddr, `QDR_OFS_ADDRESS_LOW) && pstrb[0])
                next_regs.low = pwdata[7:0];
            if (hit(paddr, `QDR_OFS_ADDRESS_MID) && pstrb[0])
                next_regs.mid = pwdata[7:0];
            if (hit(paddr, `QDR_OFS_ADDRESS_HIGH) && pstrb[0])
                next_regs.high = pwdata[7:0];
            if (hit(paddr, `QDR_OFS_DRIVE_SELECT) && pstrb[0])
                next_regs.drive = pwdata[7:0];
            if (hit(paddr, `QDR_OFS_CONFIG) && pstrb[0])
                next_cfg = pwdata[7:0];
        end
        if (wr_en && hit(paddr, `QDR_OFS_EVENT) && pstrb[0])
            next_event_bits = event_bits & ~pwdata[7:0];
        case (state)
            QDR_IDLE:
            begin
                if (issue_req && regs.status[`QDR_ST_READY])
                begin
                    next_fail = '0;
                    next_regs.status[`QDR_ST_BUSY] = 1'b1;
                    next_eject_seen = eject_request;
                    if (!cfg[`QDR_CF_SUPPORTED] || !cfg[`QDR_CF_OVL_EN])
                        next_fail.abort = 1'b1;
                    if (cfg[`QDR_CF_QUEUING] && tag_valid_limit_en
                        && regs.count[`QDR_SC_TAG_HI:`QDR_SC_TAG_LO] > tag_limit)
                        next_fail.abort = 1'b1;
                    if (cfg[`QDR_CF_REMOVABLE])
                    begin
                        next_fail.nomedium = ~medium_present;
                        next_fail.swap  = next_swap_seen;
                        next_swap_seen  = 1'b0;
                        next_fail.eject = eject_seen;
                    end
                    if (next_fail != '0)
                    begin
                        img_kind       = qdr_pkg::QDR_IMG_ERROR;
                        next_regs      = img;
                        next_regs.status[`QDR_ST_BUSY] = 1'b0;
                        next_state     = QDR_IDLE;
                    end
                    else
                    begin
                        next_state = QDR_XFER;
                    end
                end
            end
            QDR_XFER:
            begin
                if (data_ready)
                begin
                    img_kind   = qdr_pkg::QDR_IMG_DATA;
                    next_regs  = img;
                    next_state = QDR_END;
                end
                else
                begin
                    next_regs.count[`QDR_SC_LETGO]  = 1'b1;
                    next_regs.count[`QDR_SC_TOHOST] = 1'b0;
                    next_regs.count[`QDR_SC_CTRL]   = 1'b0;
                    next_regs.status[`QDR_ST_BUSY]  = 1'b0;
                    next_regs.status[`QDR_ST_READY] = 1'b1;
                    next_regs.status[`QDR_ST_XFER]  = 1'b0;
                    next_regs.status[`QDR_ST_FAIL]  = 1'b0;
                    next_regs.status[`QDR_ST_SERVICE] = more_queued;
                    next_state = QDR_RELEASED;
                end
            end
            QDR_RELEASED:
            begin
                if (data_ready || xfer_done || err_unrecov || err_crc
                    || err_range || err_notfound || err_fault)
                begin
                    next_regs.status[`QDR_ST_SERVICE] = 1'b1;
                    next_pend  = data_ready ? qdr_pkg::QDR_IMG_DATA : qdr_pkg::QDR_IMG_DONE;
                    next_state = QDR_WAIT_RESUME;
                end
            end
            QDR_WAIT_RESUME:
            begin
                if (resume_req)
                begin
                    next_regs = img;
                    next_state = (pend == qdr_pkg::QDR_IMG_DATA) ? QDR_END : QDR_IDLE;
                end
            end
            QDR_END:
            begin
                if (xfer_done)
                begin
                    img_kind   = qdr_pkg::QDR_IMG_DONE;
                    next_regs  = img;
                    next_state = QDR_IDLE;
                end
            end
            default:
            begin
                next_state = QDR_IDLE;
            end
        endcase
        // error capture during a running command
        if (state != QDR_IDLE && (err_unrecov || err_crc || err_range
            || err_notfound || err_fault))
        begin
            next_fail.unfix = fail.unfix | err_unrecov;
            next_fail.crc   = fail.crc | (err_crc & ultra_mode);
            // abort for ultra crc errors and for range without notfound
            next_fail.abort = fail.abort | (ultra_mode & err_crc) | (err_range & ~err_notfound);
            next_fail.noaddr = fail.noaddr | err_notfound;
            next_fail.fault = fail.fault | err_fault;
            next_flush = err_unrecov;
            if (state == QDR_RELEASED || state == QDR_WAIT_RESUME)
                next_pend = qdr_pkg::QDR_IMG_ERROR;
            else
            begin
                img_kind   = qdr_pkg::QDR_IMG_ERROR;
                next_regs  = img;
                next_state = QDR_IDLE;
            end
        end
        // hardware set wins over software clear
        next_event_bits = next_event_bits | {5'h00, next_flush, err_unrecov, medium_changed};
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state      <= QDR_IDLE;
            regs       <= '0;
            regs.status <= `QDR_RST_STATUS;
            fail       <= '0;
            pend       <= qdr_pkg::QDR_IMG_DONE;
            cfg        <= `QDR_RST_CONFIG;
            swap_seen  <= 1'b0;
            eject_seen <= 1'b0;
            flush      <= 1'b0;
            event_bits <= 8'h00;
        end
        else
        begin
            state      <= next_state;
            regs       <= next_regs;
            fail       <= next_fail;
            pend       <= next_pend;
            cfg        <= next_cfg;
            swap_seen  <= next_swap_seen;
            eject_seen <= next_eject_seen;
            flush      <= next_flush;
            event_bits <= next_event_bits;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux, registered data
    logic [31:0] next_prdata;
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `QDR_OFS_FAILURE_CAUSE:   next_prdata[7:0] = regs.cause;
                `QDR_OFS_TAG_AND_REASON:  next_prdata[7:0] = regs.count;
                `QDR_OFS_ADDRESS_LOW:     next_prdata[7:0] = regs.low;
                `QDR_OFS_ADDRESS_MID:     next_prdata[7:0] = regs.mid;
                `QDR_OFS_ADDRESS_HIGH:    next_prdata[7:0] = regs.high;
                `QDR_OFS_DRIVE_SELECT:    next_prdata[7:0] = regs.drive;
                `QDR_OFS_CONDITION_FLAGS: next_prdata[7:0] = regs.status;
                `QDR_OFS_EVENT:           next_prdata[7:0] = event_bits;
                `QDR_OFS_CONFIG:          next_prdata[7:0] = cfg;
                default:                  next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
            prdata <= next_prdata;
    end

    assign queue_flush = flush;
    assign cmd_active  = (state != QDR_IDLE);
    // rd_en kept for symmetry of decode
    logic unused_rd;
    assign unused_rd = rd_en;
endmodule

// *** testbench/qdr_status_assertions.sv ***
// port-level checks for the queued read status block
`timescale 1ns/1ps
module qdr_status_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        err_unrecov,
    input wire logic        queue_flush
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_status_rd;
        s_access ##0 (!pwrite && paddr == 12'h018);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    chk_ready_bit: assert property (s_status_rd ##0 !prdata[7] |-> prdata[6])
        else $error("idle status without ready");
    chk_status_na: assert property (s_status_rd |-> prdata[2:1] == 2'h0)
        else $error("status unused bits set");
    chk_zero_wait: assert property (s_access |-> pready)
        else $error("wait state inserted");
    chk_unmapped_err: assert property (s_access ##0 paddr > 12'h024 |-> pslverr)
        else $error("unmapped access accepted");
    chk_misaligned_err: assert property (s_access ##0 paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access accepted");
    chk_mapped_ok: assert property (s_access ##0 (paddr <= 12'h024 && paddr[1:0] == 2'h0)
        |-> !pslverr) else $error("mapped access refused");
    chk_upper_zero: assert property (s_access ##0 (!pwrite && !pslverr) |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    // read data only moves on a setup cycle
    chk_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    chk_flush_pulse: assert property (queue_flush |=> !queue_flush)
        else $error("flush longer than one cycle");
    chk_flush_cause: assert property (queue_flush |-> $past(err_unrecov))
        else $error("flush without unrecoverable error");
endmodule

// *** testbench/qdr_host_model.sv ***
// host adapter model: apb master operating the task-file registers
`timescale 1ns/1ps
`include "qdr_params.svh"
module qdr_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle bus shows no stale request
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    task automatic issue(input logic [4:0] tag, output logic ok);
        logic [31:0] q;
        logic        e;
        xfer(1'b0, `QDR_OFS_CONDITION_FLAGS, 32'h0, q, e);
        ok = q[6];
        if (ok === 1'b1)
        begin
            xfer(1'b1, `QDR_OFS_TAG_AND_REASON, {24'h0, tag, 3'h0}, q, e);
            xfer(1'b1, `QDR_OFS_CONTROL, 32'h1, q, e);
        end
    endtask
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the queued read status block
`timescale 1ns/1ps
`include "qdr_params.svh"
`define CHK(got, exp) \
    begin check_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  pstrb;
    logic [6:0]  ev;
    logic [4:0]  lv, lim;
    logic [27:0] fail_addr;
    logic        lim_en, queue_flush, cmd_active, er, ok;
    int          n_errors, check_count;

    always #20 pclk = ~pclk;
    qdr_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    qdr_status dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .data_ready(ev[0]), .xfer_done(ev[1]),
        .err_unrecov(ev[2]), .err_crc(ev[3]), .err_range(ev[4]), .err_notfound(ev[5]),
        .err_fault(ev[6]), .ultra_mode(lv[4]), .medium_changed(lv[3]),
        .eject_request(lv[2]), .medium_present(lv[1]), .more_queued(lv[0]),
        .fail_addr(fail_addr), .tag_valid_limit_en(lim_en), .tag_limit(lim),
        .queue_flush(queue_flush), .cmd_active(cmd_active));
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        host.xfer(1'b0, a, 32'h0, q, er);
        `CHK(q, {24'h0, e})
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, q, er);
    endtask
    task pulse(input logic [6:0] v);
        ev <= v;
        @(posedge pclk);
        ev <= 7'h00;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        rd(`QDR_OFS_CONDITION_FLAGS, 8'h40);
        rd(`QDR_OFS_CONFIG, 8'h0F);
        host.xfer(1'b0, 12'h100, 32'h0, q, er);
        `CHK(er, 1'b1)
        host.xfer(1'b1, 12'h006, 32'h0, q, er);
        `CHK(er, 1'b1)
    endtask
    task t_release;
        host.issue(5'd9, ok);
        `CHK(ok, 1'b1)
        repeat (3) @(posedge pclk);
        `CHK(cmd_active, 1'b1)
        rd(`QDR_OFS_TAG_AND_REASON, 8'h4C);
        rd(`QDR_OFS_CONDITION_FLAGS, 8'h40);
        pulse(7'h01);
        rd(`QDR_OFS_CONDITION_FLAGS, 8'h50);
        rd(`QDR_OFS_TAG_AND_REASON, 8'h4C);
        wr(`QDR_OFS_CONTROL, 8'h02);
        rd(`QDR_OFS_TAG_AND_REASON, 8'h4A);
        rd(`QDR_OFS_CONDITION_FLAGS, 8'h48);
        lv[0] <= 1'b1;
        pulse(7'h02);
        rd(`QDR_OFS_FAILURE_CAUSE, 8'h00);
        rd(`QDR_OFS_TAG_AND_REASON, 8'h4B);
        rd(`QDR_OFS_CONDITION_FLAGS, 8'h50);
        `CHK(cmd_active, 1'b0)
        lv[0] <= 1'b0;
    endtask
    task t_abort;
        // config, tag, expected tag_and_reason; limit enable on the third entry
        logic [20:0] tbl [4] = '{{8'h0D, 5'd5, 8'h2B}, {8'h07, 5'd6, 8'h33},
                                 {8'h0F, 5'd5, 8'h2B}, {8'h0C, 5'd0, 8'h03}};
        for (int i = 0; i < 4; i++)
        begin
            wr(`QDR_OFS_CONFIG, tbl[i][20:13]);
            lim_en <= (i == 2);
            host.issue(tbl[i][12:8], ok);
            repeat (2) @(posedge pclk);
            rd(`QDR_OFS_FAILURE_CAUSE, 8'h04);
            rd(`QDR_OFS_TAG_AND_REASON, tbl[i][7:0]);
            rd(`QDR_OFS_CONDITION_FLAGS, 8'h41);
        end
        wr(`QDR_OFS_CONFIG, 8'h0F);
        lim_en <= 1'b0;
    endtask
    task t_unrecov;
        fail_addr <= 28'hA5C3E71;
        host.issue(5'd3, ok);
        pulse(7'h01);
        @(posedge pclk);
        pulse(7'h04);
        #1;
        `CHK(queue_flush, 1'b1)
        host.xfer(1'b0, `QDR_OFS_FAILURE_CAUSE, 32'h0, q, er);
        `CHK(q[7:1], 7'h20)
        rd(`QDR_OFS_CONDITION_FLAGS, 8'h41);
        rd(`QDR_OFS_TAG_AND_REASON, 8'h1B);
        rd(`QDR_OFS_ADDRESS_LOW, 8'h71);
        rd(`QDR_OFS_ADDRESS_MID, 8'h3E);
        rd(`QDR_OFS_ADDRESS_HIGH, 8'h5C);
        host.xfer(1'b0, `QDR_OFS_DRIVE_SELECT, 32'h0, q, er);
        `CHK(q[3:0], 4'hA)
    endtask
    task t_medium;
        // swapped, eject asked, no medium
        lv <= 5'h0C;
        host.issue(5'd2, ok);
        lv <= 5'h02;
        rd(`QDR_OFS_FAILURE_CAUSE, 8'h2A);
        rd(`QDR_OFS_TAG_AND_REASON, 8'h13);
        wr(`QDR_OFS_CONTROL, 8'h04);
        wr(`QDR_OFS_CONFIG, 8'h07);
        host.issue(5'd2, ok);
        rd(`QDR_OFS_FAILURE_CAUSE, 8'h04);
        wr(`QDR_OFS_CONFIG, 8'h0F);
        for (int i = 0; i < 2; i++)
        begin
            host.issue(5'd1, ok);
            pulse(7'h01);
            @(posedge pclk);
            pulse(i ? 7'h10 : 7'h20);
            rd(`QDR_OFS_FAILURE_CAUSE, i ? 8'h04 : 8'h10);
        end
    endtask
    task t_crc;
        lv[4] <= 1'b1;
        host.issue(5'd4, ok);
        pulse(7'h01);
        @(posedge pclk);
        pulse(7'h08);
        rd(`QDR_OFS_FAILURE_CAUSE, 8'h84);
        rd(`QDR_OFS_CONDITION_FLAGS, 8'h41);
        lv[4] <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        ev = 7'h00;
        lv = 5'h02;
        lim = 5'd3;
        lim_en = 1'b0;
        fail_addr = 28'h0;
        n_errors = 0;
        check_count = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_release;
        t_abort;
        t_unrecov;
        t_medium;
        t_crc;
        stop_test;
    end
    // whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        stop_test;
    end
endmodule
bind qdr_status qdr_status_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .err_unrecov(err_unrecov), .queue_flush(queue_flush));
